// ==== inc/usart_pkg.sv ====
// How it works
// - Break is start, twelve zeros, stop
// - Data write with break request starts Break
// - Break request self-clears after Break stop bit
// - Shifter-empty flag tracks Break like characters
// - Break seen as flag, framing error, 00h
// - Wake-on-break flags the fall, clears on the rise, then receives
// - Synchronous mode: no framing, half-duplex line
// - Master when clocked, master, enabled; receive enables
// - Master drives clock, one cycle per bit
// - Polarity sets clock idle level and edge
// - Holding register waits for empty shifter
// - Master transmit drives data, changes on lead
// - Master receive releases data driver
// - Single receive clocks one character, then clears
// - Clearing continuous receive stops clock, discards
// - Both enables: single clears, continuous continues
// - Sample on trailing edge into two-entry FIFO
// - Slave never drives clock, follows master
// - Third character sets overrun, FIFO kept
// - Overrun clears by read after single receive, else by disabling
// - Ninth bit shifted and shown in status
package usart_pkg;
  localparam logic [7:0] OFS_TXCTL = 8'h00;
  localparam logic [7:0] OFS_RXCTL = 8'h04;
  localparam logic [7:0] OFS_BAUDCTL = 8'h08;
  localparam logic [7:0] OFS_BRG = 8'h0C;
  localparam logic [7:0] OFS_TXDATA = 8'h10;
  localparam logic [7:0] OFS_RXDATA = 8'h14;
  localparam int TXC_EN = 0;
  localparam int TXC_BREAK_SEND_REQUEST = 1;
  localparam int TXC_TX9 = 2;
  localparam int TXC_TRANSMIT_NINTH_BIT = 3;
  localparam int TXC_SYNC = 4;
  localparam int TXC_MASTER = 5;
  localparam int TXC_SHIFTER_EMPTY_FLAG = 6;
  localparam int TXC_TRANSMIT_BUFFER_EMPTY_FLAG = 7;
  localparam int RXC_PORT_ENABLE = 0;
  localparam int RXC_SINGLE_RECEIVE_ENABLE = 1;
  localparam int RXC_CONTINUOUS_RECEIVE_ENABLE = 2;
  localparam int RXC_RX9 = 3;
  localparam int RXC_RECEIVED_NINTH_BIT = 4;
  localparam int RXC_FRAMING_ERROR_FLAG = 5;
  localparam int RXC_OVERRUN_ERROR_FLAG = 6;
  localparam int RXC_RECEIVE_FLAG = 7;
  localparam int BC_CLOCK_POLARITY_SELECT = 0;
  localparam int BC_WUE = 1;
  localparam logic [15:0] BRG_RESET = 16'h0009;
  localparam logic [3:0] LEN_SYNC8 = 4'h8;
  localparam logic [3:0] LEN_SYNC9 = 4'h9;
  localparam logic [3:0] LEN_BREAK = 4'hE;
  localparam logic [13:0] BREAK_BITS = 14'h2000;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
  typedef struct packed {
    logic framing_error_flag;
    logic [8:0] data;
  } rx_entry_t;
  typedef struct packed {
    logic [13:0] bits;
    logic [3:0] len;
  } tx_frame_t;
  typedef enum logic [2:0] {
    ARX_IDLE = 3'h1,
    ARX_START = 3'h2,
    ARX_BITS = 3'h4
  } arx_state_t;
endpackage : usart_pkg

// ==== core/usart_break_sync.sv ====
module usart_break_sync (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic WB_ACK_O,
  output logic [31:0] WB_DAT_O,
  input wire logic DATA_IN,
  output logic DATA_OUT,
  output logic DATA_OE_N,
  input wire logic CLK_IN,
  output logic CLK_OUT,
  output logic CLK_OE_N
);
  logic transmitter_enable, break_send_request, nine_bit_transmit, transmit_ninth_bit;
  logic clocked_mode_select, clock_source_master;
  logic port_enable, single_receive_enable, continuous_receive_enable, nine_bit_receive;
  logic clock_polarity_select, wake_on_break;
  logic [15:0] baud_divisor;
  logic [31:0] next_rdata;

  // Bus decode: the write and the FIFO pop happen at the edge where ack is sampled
  wire req = WB_CYC_I & WB_STB_I;
  wire wr_fire = req & WB_WE_I & WB_ACK_O;
  wire rd_fire = req & ~WB_WE_I & WB_ACK_O;
  wire wr_lo = wr_fire & WB_SEL_I[0];
  wire wr_txctl = wr_lo & (WB_ADR_I == usart_pkg::OFS_TXCTL);
  wire wr_rxctl = wr_lo & (WB_ADR_I == usart_pkg::OFS_RXCTL);
  wire wr_baudctl = wr_lo & (WB_ADR_I == usart_pkg::OFS_BAUDCTL);
  wire wr_brg = wr_fire & (WB_ADR_I == usart_pkg::OFS_BRG);
  wire wr_txdata = wr_lo & (WB_ADR_I == usart_pkg::OFS_TXDATA);
  wire rd_pop = rd_fire & (WB_ADR_I == usart_pkg::OFS_RXDATA);

  // Pin synchronisers; stage 0 feeds only stage 1
  logic [2:0] din_sync, ck_sync;
  wire din = din_sync[1];
  wire din_fall = din_sync[2] & ~din_sync[1];
  wire din_rise = ~din_sync[2] & din_sync[1];
  wire ck_act = ck_sync[1] ^ clock_polarity_select;
  wire ck_prev_act = ck_sync[2] ^ clock_polarity_select;
  wire slave_lead = ck_act & ~ck_prev_act;
  wire slave_trail = ~ck_act & ck_prev_act;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      din_sync <= 3'h7;
      ck_sync <= 3'h0;
    end else begin
      din_sync <= {din_sync[1:0], DATA_IN};
      ck_sync <= {ck_sync[1:0], CLK_IN};
    end
  end

  // Operating mode
  wire sync_on = port_enable & clocked_mode_select;
  wire master = sync_on & clock_source_master;
  wire slave = sync_on & ~clock_source_master;
  wire rx_mode = single_receive_enable | continuous_receive_enable;
  wire tx_mode = ~rx_mode;

  logic overrun, ovr_single;
  logic tx_busy, tx_adv, tx_brk;
  logic [13:0] tx_sh;
  logic [3:0] tx_left;
  logic [15:0] baud_cnt;
  logic mclk;

  // Master clock: one tick per half bit; clocks run while transmit bits remain or master receive is enabled with no overrun
  wire rx_sync_on = sync_on & rx_mode & ~overrun;
  wire tx_gen = tx_busy & (~clocked_mode_select | (clock_source_master & tx_mode));
  wire gen_run = port_enable & (tx_gen | (master & rx_sync_on));
  wire tick = gen_run & (baud_cnt == baud_divisor);
  wire gen_lead = tick & ~mclk;
  wire gen_trail = tick & mclk;
  wire lead = slave ? slave_lead : gen_lead;
  wire trail = slave ? slave_trail : gen_trail;

  always_ff @(posedge CLK_SYS) begin
    if (RST || !gen_run) begin
      baud_cnt <= 16'h0000;
      mclk <= 1'b0;
    end else if (tick) begin
      baud_cnt <= 16'h0000;
      mclk <= ~mclk;
    end else begin
      baud_cnt <= 16'(baud_cnt + 16'h0001);
    end
  end

  // Transmit holding register and shifter
  logic thr_full, thr_brk, brk_busy;
  logic [8:0] thr_data;

  function automatic usart_pkg::tx_frame_t frame_of(input logic [8:0] d, input logic nine,
                                                    input logic brk, input logic sync);
    usart_pkg::tx_frame_t f;
    f.bits = {5'h1F, d};
    f.len = nine ? usart_pkg::LEN_SYNC9 : usart_pkg::LEN_SYNC8;
    if (brk) begin
      f.bits = usart_pkg::BREAK_BITS;
      f.len = usart_pkg::LEN_BREAK;
    end else if (!sync && nine) begin
      f.bits = {3'h7, 1'b1, d, 1'b0};
      f.len = 4'(usart_pkg::LEN_SYNC9 + 4'h2);
    end else if (!sync) begin
      f.bits = {4'hF, 1'b1, d[7:0], 1'b0};
      f.len = 4'(usart_pkg::LEN_SYNC8 + 4'h2);
    end
    return f;
  endfunction : frame_of

  wire tx_load = thr_full & ~tx_busy & transmitter_enable & port_enable &
                 (~clocked_mode_select | tx_mode);
  wire tx_last = tx_busy & trail & (tx_left == 4'h1);
  usart_pkg::tx_frame_t frame;
  assign frame = frame_of(thr_data, nine_bit_transmit, thr_brk, clocked_mode_select);

  always_ff @(posedge CLK_SYS) begin
    if (RST || !port_enable) begin
      thr_full <= 1'b0;
      thr_brk <= 1'b0;
      thr_data <= 9'h000;
    end else if (wr_txdata && !thr_full && transmitter_enable) begin
      thr_full <= 1'b1;
      thr_data <= {transmit_ninth_bit, WB_DAT_I[7:0]};
      // Only the first write after the request becomes the Break; the next is the payload
      thr_brk <= break_send_request & ~brk_busy & ~clocked_mode_select;
    end else if (tx_load) begin
      thr_full <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST || !port_enable) begin
      brk_busy <= 1'b0;
    end else if (wr_txdata && !thr_full && transmitter_enable && break_send_request &&
                 !clocked_mode_select) begin
      brk_busy <= 1'b1;
    end else if (tx_last && tx_brk) begin
      brk_busy <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST || !port_enable) begin
      tx_busy <= 1'b0;
      tx_adv <= 1'b0;
      tx_brk <= 1'b0;
      tx_sh <= 14'h3FFF;
      tx_left <= 4'h0;
    end else if (tx_load) begin
      tx_busy <= 1'b1;
      tx_sh <= frame.bits;
      tx_left <= frame.len;
      tx_adv <= 1'b0;
      tx_brk <= thr_brk;
    end else if (tx_busy && trail) begin
      tx_left <= 4'(tx_left - 4'h1);
      if (tx_left == 4'h1) begin
        tx_busy <= 1'b0;
      end
      if (clocked_mode_select) begin
        tx_adv <= 1'b1;
      end else begin
        tx_sh <= {1'b1, tx_sh[13:1]};
      end
    end else if (tx_busy && lead && tx_adv) begin
      tx_sh <= {1'b1, tx_sh[13:1]};
      tx_adv <= 1'b0;
    end
  end

  // Synchronous receive shifter, sampled on the trailing edge
  logic [8:0] rx_sh;
  logic [3:0] rx_bits;
  wire [3:0] srx_len = nine_bit_receive ? usart_pkg::LEN_SYNC9 : usart_pkg::LEN_SYNC8;
  wire srx_done = rx_sync_on & trail & (rx_bits == 4'(srx_len - 4'h1));
  wire [8:0] srx_data = nine_bit_receive ? {din, rx_sh[8:1]} : {1'b0, din, rx_sh[8:2]};

  always_ff @(posedge CLK_SYS) begin
    if (RST || !rx_sync_on) begin
      rx_bits <= 4'h0;
      rx_sh <= 9'h000;
    end else if (trail) begin
      rx_sh <= {din, rx_sh[8:1]};
      rx_bits <= srx_done ? 4'h0 : 4'(rx_bits + 4'h1);
    end
  end

  // Asynchronous receiver; a Break arrives as zero data with a framing error
  usart_pkg::arx_state_t arx_state;
  logic [16:0] arx_cnt;
  logic [3:0] arx_idx;
  logic [9:0] arx_sh;
  logic wake_low, wake_pend;
  wire arx_on = port_enable & ~clocked_mode_select & continuous_receive_enable & ~overrun;
  wire arx_sample = (arx_state == usart_pkg::ARX_BITS) & (arx_cnt == 17'h00000);
  wire arx_done = arx_sample & (arx_idx == srx_len);
  wire [8:0] arx_data = nine_bit_receive ? arx_sh[9:1] : {1'b0, arx_sh[9:2]};

  always_ff @(posedge CLK_SYS) begin
    if (RST || !arx_on) begin
      arx_state <= usart_pkg::ARX_IDLE;
      arx_cnt <= 17'h00000;
      arx_idx <= 4'h0;
      arx_sh <= 10'h000;
    end else begin
      case (arx_state)
        usart_pkg::ARX_IDLE: begin
          if (din_fall && !wake_on_break) begin
            arx_state <= usart_pkg::ARX_START;
            arx_cnt <= {1'b0, baud_divisor};
          end
        end
        usart_pkg::ARX_START: begin
          if (arx_cnt != 17'h00000) begin
            arx_cnt <= 17'(arx_cnt - 17'h00001);
          end else if (!din) begin
            arx_state <= usart_pkg::ARX_BITS;
            arx_cnt <= {baud_divisor, 1'b1};
            arx_idx <= 4'h0;
          end else begin
            arx_state <= usart_pkg::ARX_IDLE;
          end
        end
        usart_pkg::ARX_BITS: begin
          if (arx_cnt != 17'h00000) begin
            arx_cnt <= 17'(arx_cnt - 17'h00001);
          end else begin
            arx_sh <= {din, arx_sh[9:1]};
            arx_idx <= 4'(arx_idx + 4'h1);
            arx_cnt <= {baud_divisor, 1'b1};
            if (arx_done) begin
              arx_state <= usart_pkg::ARX_IDLE;
            end
          end
        end
        default: arx_state <= usart_pkg::ARX_IDLE;
      endcase
    end
  end

  // Wake: falling edge flags the receiver, rising edge ends the Break
  always_ff @(posedge CLK_SYS) begin
    if (RST || !port_enable) begin
      wake_low <= 1'b0;
      wake_pend <= 1'b0;
    end else begin
      if (wake_on_break && !clocked_mode_select && din_fall) begin
        wake_low <= 1'b1;
        wake_pend <= 1'b1;
      end else begin
        if (din_rise) begin
          wake_low <= 1'b0;
        end
        if (rd_pop) begin
          wake_pend <= 1'b0;
        end
      end
    end
  end

  // Two-entry receive FIFO
  usart_pkg::rx_entry_t fifo [2];
  logic [1:0] fifo_cnt;
  logic rd_idx;
  usart_pkg::rx_entry_t push_entry, fifo_top;
  wire push_req = srx_done | arx_done;
  wire pop_ok = rd_pop & (fifo_cnt != 2'h0);
  wire push_ok = push_req & ~overrun & ((fifo_cnt != usart_pkg::FIFO_DEPTH) | pop_ok);
  wire wr_idx = rd_idx ^ (fifo_cnt == 2'h1);
  wire receive_flag = (fifo_cnt != 2'h0) | wake_pend;
  assign push_entry = srx_done ? '{framing_error_flag: 1'b0, data: srx_data} :
                                 '{framing_error_flag: ~din, data: arx_data};
  assign fifo_top = fifo[rd_idx];

  always_ff @(posedge CLK_SYS) begin
    if (push_ok) begin
      fifo[wr_idx] <= push_entry;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST || !port_enable) begin
      fifo_cnt <= 2'h0;
      rd_idx <= 1'b0;
      overrun <= 1'b0;
      ovr_single <= 1'b0;
    end else begin
      fifo_cnt <= 2'(fifo_cnt + {1'b0, push_ok} - {1'b0, pop_ok});
      if (pop_ok) begin
        rd_idx <= ~rd_idx;
      end
      if (push_req && !push_ok && !overrun) begin
        overrun <= 1'b1;
        ovr_single <= single_receive_enable & ~continuous_receive_enable;
      end else if (overrun && ((ovr_single && rd_pop) ||
                               (!ovr_single && !continuous_receive_enable))) begin
        overrun <= 1'b0;
      end
    end
  end

  // Control registers; software keeps priority over hardware self-clears
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      transmitter_enable <= 1'b0;
      break_send_request <= 1'b0;
      nine_bit_transmit <= 1'b0;
      transmit_ninth_bit <= 1'b0;
      clocked_mode_select <= 1'b0;
      clock_source_master <= 1'b0;
    end else if (wr_txctl) begin
      transmitter_enable <= WB_DAT_I[usart_pkg::TXC_EN];
      break_send_request <= WB_DAT_I[usart_pkg::TXC_BREAK_SEND_REQUEST];
      nine_bit_transmit <= WB_DAT_I[usart_pkg::TXC_TX9];
      transmit_ninth_bit <= WB_DAT_I[usart_pkg::TXC_TRANSMIT_NINTH_BIT];
      clocked_mode_select <= WB_DAT_I[usart_pkg::TXC_SYNC];
      clock_source_master <= WB_DAT_I[usart_pkg::TXC_MASTER];
    end else if (tx_last && tx_brk) begin
      break_send_request <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      port_enable <= 1'b0;
      single_receive_enable <= 1'b0;
      continuous_receive_enable <= 1'b0;
      nine_bit_receive <= 1'b0;
    end else if (wr_rxctl) begin
      port_enable <= WB_DAT_I[usart_pkg::RXC_PORT_ENABLE];
      single_receive_enable <= WB_DAT_I[usart_pkg::RXC_SINGLE_RECEIVE_ENABLE];
      continuous_receive_enable <= WB_DAT_I[usart_pkg::RXC_CONTINUOUS_RECEIVE_ENABLE];
      nine_bit_receive <= WB_DAT_I[usart_pkg::RXC_RX9];
    end else if (srx_done && master) begin
      single_receive_enable <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      clock_polarity_select <= 1'b0;
      wake_on_break <= 1'b0;
      baud_divisor <= usart_pkg::BRG_RESET;
    end else begin
      if (wr_baudctl) begin
        clock_polarity_select <= WB_DAT_I[usart_pkg::BC_CLOCK_POLARITY_SELECT];
        wake_on_break <= WB_DAT_I[usart_pkg::BC_WUE];
      end else if (wake_low && din_rise) begin
        wake_on_break <= 1'b0;
      end
      if (wr_brg && WB_SEL_I[0]) begin
        baud_divisor[7:0] <= WB_DAT_I[7:0];
      end
      if (wr_brg && WB_SEL_I[1]) begin
        baud_divisor[15:8] <= WB_DAT_I[15:8];
      end
    end
  end

  // Read mux; unmapped addresses answer with zero
  wire [7:0] txctl_rd = {~thr_full, ~tx_busy, clock_source_master, clocked_mode_select,
                         transmit_ninth_bit, nine_bit_transmit, break_send_request,
                         transmitter_enable};
  wire [7:0] rxctl_rd = {receive_flag, overrun, fifo_top.framing_error_flag & (fifo_cnt != 2'h0),
                         fifo_top.data[8], nine_bit_receive, continuous_receive_enable,
                         single_receive_enable, port_enable};
  always_comb begin
    next_rdata = 32'h00000000;
    case (WB_ADR_I)
      usart_pkg::OFS_TXCTL: next_rdata = {24'h000000, txctl_rd};
      usart_pkg::OFS_RXCTL: next_rdata = {24'h000000, rxctl_rd};
      usart_pkg::OFS_BAUDCTL: next_rdata = {30'h00000000, wake_on_break, clock_polarity_select};
      usart_pkg::OFS_BRG: next_rdata = {16'h0000, baud_divisor};
      usart_pkg::OFS_RXDATA: next_rdata = {24'h000000, fifo_top.data[7:0]};
      default: next_rdata = 32'h00000000;
    endcase
  end

  // Pins: drivers follow the mode automatically
  wire tx_line = tx_busy ? tx_sh[0] : 1'b1;
  wire next_data_out = (sync_on & tx_mode) ? tx_sh[0] : 1'b1;
  wire next_data_oe_n = ~(sync_on & tx_mode & transmitter_enable);
  wire next_clk_out = master ? (mclk ^ clock_polarity_select) :
                      (sync_on ? clock_polarity_select : tx_line);
  wire next_clk_oe_n = ~(master | (port_enable & ~clocked_mode_select & transmitter_enable));

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
      DATA_OUT <= 1'b1;
      DATA_OE_N <= 1'b1;
      CLK_OUT <= 1'b1;
      CLK_OE_N <= 1'b1;
    end else begin
      WB_ACK_O <= req & ~WB_ACK_O;
      WB_DAT_O <= next_rdata;
      DATA_OUT <= next_data_out;
      DATA_OE_N <= next_data_oe_n;
      CLK_OUT <= next_clk_out;
      CLK_OE_N <= next_clk_oe_n;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  a_break_zero_bits: assert property (
    (tx_busy & tx_brk) |-> (tx_sh[0] == (tx_left == 4'h1)))
    else $error("break frame bit is not zero before its stop bit");
  a_break_req_clear: assert property (
    (tx_last & tx_brk & ~wr_txctl) |=> (~break_send_request & ~brk_busy))
    else $error("break request still set after break stop bit");
  a_shift_load_now: assert property (
    (thr_full & ~tx_busy & transmitter_enable & port_enable & ~clocked_mode_select)
      |=> (tx_busy & ~thr_full))
    else $error("holding register not moved into idle shifter");
  a_sync_no_frame: assert property (
    (tx_load & clocked_mode_select) |=>
      (tx_left == (nine_bit_transmit ? usart_pkg::LEN_SYNC9 : usart_pkg::LEN_SYNC8)))
    else $error("synchronous character length includes framing");
  a_clk_idle_level: assert property (
    (master & ~gen_run)[*3] |-> (CLK_OUT == $past(clock_polarity_select)))
    else $error("master clock not at its idle level");
  a_rx_data_release: assert property (
    (sync_on & rx_mode)[*2] |-> DATA_OE_N)
    else $error("data driver enabled during synchronous receive");
  a_single_one_char: assert property (
    (srx_done & master & ~continuous_receive_enable & ~wr_rxctl)
      |=> (~single_receive_enable ##1 (~gen_run | tx_busy)))
    else $error("single receive not ended after one character");
  a_continuous_receive_enable_stop_clock: assert property (
    (master & $fell(continuous_receive_enable) & ~single_receive_enable & ~tx_busy)
      |=> (~mclk & (rx_bits == 4'h0)))
    else $error("clock or partial character kept after continuous receive cleared");
  a_overrun_keep: assert property (
    (push_req & ~overrun & (fifo_cnt == 2'h2) & ~pop_ok)
      |=> (overrun & (fifo_cnt == 2'h2) & $stable(fifo[0]) & $stable(fifo[1])))
    else $error("overrun not flagged or stored characters disturbed");
  a_overrun_read_clear: assert property (
    (overrun & ovr_single & rd_pop) |=> ~overrun)
    else $error("single receive overrun not cleared by data read");

  c_break_sent: cover property (tx_last & tx_brk);
  c_break_seen: cover property (push_ok & arx_done & push_entry.framing_error_flag & (push_entry.data == 9'h000));
  c_sync_master_rx: cover property (srx_done & master);
  c_overrun: cover property (push_req & ~push_ok & ~overrun);
  c_wake_event: cover property (wake_pend & ~wake_on_break);
endmodule : usart_break_sync

// ==== dv/lin_peer.sv ====
module lin_peer (
  input wire logic clk,
  input wire logic ck_o,
  input wire logic ck_oe_n,
  input wire logic d_o,
  input wire logic d_oe_n,
  output logic d_i,
  output logic ck_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic line = 1'b1;
  logic ck_q = 1'b0;
  logic hold = 1'b1;
  logic [7:0] pat = 8'h00;
  logic [15:0] cap = 16'h0000;
  int pos = 0;
  int leads = 0;
  int lows = 0;
  int runs = 0;
  int longest = 0;
  initial ck_i = 1'b0;
  // The peer only drives the data line while the device has released it
  assign d_i = d_oe_n ? line : d_o;
  // Answers on the clock edge itself, as a real slave does, not a system clock later
  always @(posedge ck_o) begin
    if (!ck_oe_n && !hold) begin
      line <= pat[pos];
      pos <= (pos + 1) % 8;
    end
  end
  always @(posedge clk) begin
    ck_q <= ck_o;
    lows <= ck_o ? 0 : lows + 1;
    if (ck_o && !ck_q && !ck_oe_n) begin
      leads <= leads + 1;
    end
    if (!ck_o && ck_q && !ck_oe_n && !d_oe_n) begin
      cap <= {d_o, cap[15:1]};
    end
    if (ck_o && !ck_q) begin
      runs <= runs + 1;
      if (lows > longest) begin
        longest <= lows;
      end
    end
  end
  task load(input logic [7:0] p);
    pat = p;
    pos = 0;
    leads = 0;
    hold = 0;
  endtask : load
  task clr();
    hold = 1;
    runs = 0;
    longest = 0;
  endtask : clr
  task low(input int n);
    hold = 1;
    line <= 1'b0;
    repeat (n) @(posedge clk);
    line <= 1'b1;
  endtask : low
  // Link clock runs only inside the frame, idle low between frames
  task slave(input logic [7:0] p);
    hold = 1;
    #7;
    for (int i = 0; i < 8; i++) begin
      ck_i = 1'b1;
      line = p[i];
      #80;
      ck_i = 1'b0;
      #80;
    end
  endtask : slave
endmodule : lin_peer

// ==== dv/usart_break_and_sync_master_test.sv ====
module usart_break_and_sync_master_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] TXC = usart_pkg::OFS_TXCTL, RXC = usart_pkg::OFS_RXCTL;
  localparam logic [7:0] BDC = usart_pkg::OFS_BAUDCTL, BRG = usart_pkg::OFS_BRG;
  localparam logic [7:0] TXD = usart_pkg::OFS_TXDATA, RXD = usart_pkg::OFS_RXDATA;
  localparam logic [31:0] EN = 32'h1 << usart_pkg::TXC_EN, SB = 32'h1 << usart_pkg::TXC_BREAK_SEND_REQUEST;
  localparam logic [31:0] SY = 32'h1 << usart_pkg::TXC_SYNC, MS = 32'h1 << usart_pkg::TXC_MASTER;
  localparam logic [31:0] SP = 32'h1 << usart_pkg::RXC_PORT_ENABLE, SR = 32'h1 << usart_pkg::RXC_SINGLE_RECEIVE_ENABLE;
  localparam logic [31:0] CR = 32'h1 << usart_pkg::RXC_CONTINUOUS_RECEIVE_ENABLE, WU = 32'h1 << usart_pkg::BC_WUE;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h00000000;
  logic [3:0] sel = 4'hF;
  logic [31:0] rd;
  logic [31:0] dat_o;
  logic ack, d_o, d_oe_n, ck_o, ck_oe_n, d_i, ck_i;
  int bad_count = 0;
  int total_checks = 0;
  int cyc_n = 0;
  always #10 clk_sys = ~clk_sys;
  usart_break_sync usart_break_sync_i (.CLK_SYS(clk_sys), .RST(rst), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd),
    .WB_ACK_O(ack), .WB_DAT_O(dat_o), .DATA_IN(d_i), .DATA_OUT(d_o), .DATA_OE_N(d_oe_n),
    .CLK_IN(ck_i), .CLK_OUT(ck_o), .CLK_OE_N(ck_oe_n));
  lin_peer lin_peer_i (.clk(clk_sys), .ck_o(ck_o), .ck_oe_n(ck_oe_n), .d_o(d_o),
    .d_oe_n(d_oe_n), .d_i(d_i), .ck_i(ck_i));
  task close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Bounded wait guards against a slave that never acknowledges
  task wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= v;
    do @(posedge clk_sys); while (ack !== 1'b1 && ++n < 50);
    check("ack", 32'(ack), 32'h1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_sys);
  endtask : wb
  task rdc(input logic [7:0] a, input int b, input logic e, input string nm);
    wb(1'b0, a, 32'h0);
    check(nm, 32'(rd[b]), 32'(e));
  endtask : rdc
  task wait_bit(input logic [7:0] a, input int b);
    int n;
    n = 0;
    do wb(1'b0, a, 32'h0); while (rd[b] !== 1'b1 && ++n < 400);
  endtask : wait_bit
  always @(posedge clk_sys) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 60000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    wb(1'b0, BRG, 32'h0);
    check("brg reset", rd, 32'(usart_pkg::BRG_RESET));
    rdc(TXC, usart_pkg::TXC_SHIFTER_EMPTY_FLAG, 1'b1, "shifter_empty_flag idle");
    wb(1'b0, 8'hFC, 32'h0);
    check("unmapped", rd, 32'h0);
    sel <= 4'h1;
    wb(1'b1, BRG, 32'hFF03);
    sel <= 4'hF;
    wb(1'b0, BRG, 32'h0);
    check("brg lane", rd, 32'h3);
    wb(1'b1, RXC, SP);
    wb(1'b1, TXC, EN | SY | MS);
    // Pin registers follow the mode one edge after the write
    @(posedge clk_sys);
    check("ck idle low", 32'(ck_o), 32'h0);
    wb(1'b1, TXD, 32'hA5);
    wb(1'b1, TXD, 32'h3C);
    // Shifter looks idle for one cycle between characters; wait for the buffer first
    wait_bit(TXC, usart_pkg::TXC_TRANSMIT_BUFFER_EMPTY_FLAG);
    wait_bit(TXC, usart_pkg::TXC_SHIFTER_EMPTY_FLAG);
    repeat (4) @(posedge clk_sys);
    check("tx pair", 32'(lin_peer_i.cap), 32'h3CA5);
    check("tx clocks", 32'(lin_peer_i.leads), 32'd16);
    wb(1'b1, BDC, 32'h1 << usart_pkg::BC_CLOCK_POLARITY_SELECT);
    wb(1'b0, BDC, 32'h0);
    check("ck idle high", 32'(ck_o), 32'h1);
    wb(1'b1, BDC, 32'h0);
    lin_peer_i.load(8'h96);
    wb(1'b1, RXC, SP | SR);
    @(posedge ck_o);
    check("rx release", 32'(d_oe_n), 32'h1);
    wait_bit(RXC, usart_pkg::RXC_RECEIVE_FLAG);
    check("single_receive_enable clr", 32'(rd[usart_pkg::RXC_SINGLE_RECEIVE_ENABLE]), 32'h0);
    wb(1'b0, RXD, 32'h0);
    check("rx single", rd, 32'h96);
    check("rx clocks", 32'(lin_peer_i.leads), 32'd8);
    lin_peer_i.load(8'h5A);
    wb(1'b1, RXC, SP | CR);
    wait_bit(RXC, usart_pkg::RXC_OVERRUN_ERROR_FLAG);
    wb(1'b0, RXD, 32'h0);
    check("fifo 1", rd, 32'h5A);
    rdc(RXC, usart_pkg::RXC_RECEIVE_FLAG, 1'b1, "receive_flag held");
    wb(1'b0, RXD, 32'h0);
    check("fifo 2", rd, 32'h5A);
    rdc(RXC, usart_pkg::RXC_OVERRUN_ERROR_FLAG, 1'b1, "overrun_error_flag held");
    wb(1'b1, RXC, SP);
    rdc(RXC, usart_pkg::RXC_OVERRUN_ERROR_FLAG, 1'b0, "overrun_error_flag clr");
    wb(1'b1, RXC, SP | CR);
    repeat (30) @(posedge clk_sys);
    wb(1'b1, RXC, SP);
    rdc(RXC, usart_pkg::RXC_RECEIVE_FLAG, 1'b0, "partial drop");
    check("ck stopped", 32'(ck_o), 32'h0);
    wb(1'b1, TXC, EN | SY);
    wb(1'b1, RXC, SP | CR);
    lin_peer_i.slave(8'hC3);
    @(posedge clk_sys);
    wait_bit(RXC, usart_pkg::RXC_RECEIVE_FLAG);
    check("slave ck", 32'(ck_oe_n), 32'h1);
    wb(1'b0, RXD, 32'h0);
    check("slave rx", rd, 32'hC3);
    wb(1'b1, TXC, EN | SB);
    wb(1'b1, RXC, SP);
    lin_peer_i.clr();
    wb(1'b1, TXD, 32'hFF);
    wb(1'b1, TXD, 32'h55);
    rdc(TXC, usart_pkg::TXC_SHIFTER_EMPTY_FLAG, 1'b0, "shifter_empty_flag busy");
    wait_bit(TXC, usart_pkg::TXC_TRANSMIT_BUFFER_EMPTY_FLAG);
    wait_bit(TXC, usart_pkg::TXC_SHIFTER_EMPTY_FLAG);
    check("break_send_request clr", 32'(rd[usart_pkg::TXC_BREAK_SEND_REQUEST]), 32'h0);
    check("break low", 32'(lin_peer_i.longest), 32'd104);
    check("low runs", 32'(lin_peer_i.runs), 32'd6);
    wb(1'b1, RXC, SP | CR);
    lin_peer_i.low(104);
    wait_bit(RXC, usart_pkg::RXC_RECEIVE_FLAG);
    check("framing_error_flag", 32'(rd[usart_pkg::RXC_FRAMING_ERROR_FLAG]), 32'h1);
    wb(1'b0, RXD, 32'h0);
    check("break data", rd, 32'h0);
    wb(1'b1, RXC, 32'h0);
    wb(1'b1, RXC, SP | CR);
    wb(1'b1, BDC, WU);
    lin_peer_i.low(104);
    rdc(RXC, usart_pkg::RXC_RECEIVE_FLAG, 1'b1, "wake flag");
    rdc(BDC, usart_pkg::BC_WUE, 1'b0, "wue clr");
    close_out();
  end
endmodule : usart_break_and_sync_master_test
